// [rtl/hsw_ctrl.sv]
// Mode, channel and diagnosis control of the four-channel load switch
`timescale 1ns/100ps
module hsw_ctrl #(
  parameter int RESTART_CYCLES = hsw_pkg::RESTART_CYC, // Restart wait, shorten in sim
  parameter logic [15:0] DEN_MIN = hsw_pkg::DEN_MIN_CYC // Long enable pulse length
) (
  input wire logic sys_clk, // Core clock, 200 MHz
  input wire logic resetn, // Asynchronous reset, active low
  input wire hsw_pkg::hsw_pins_s pins, // Logic pins, asynchronous
  input wire hsw_pkg::hsw_supply_s supply, // Supply comparators, asynchronous
  input wire logic retry_busy, // Protection restart counter nonzero
  output logic [hsw_pkg::NUM_CH-1:0] chan_drive, // Channel gate enables
  output logic sense_output_oe, // Sense output driven, else floating
  output logic [hsw_pkg::PICK_W-1:0] sense_sel, // Channel under diagnosis
  output logic diag_on_state, // On-state diagnosis allowed
  output logic protect_en, // Protection mechanisms armed
  output logic [hsw_pkg::NUM_CH-1:0] latch_clear, // Latch clear pulse per channel
  output logic power_on, // Supply good indication
  output hsw_pkg::hsw_mode_e mode // Present operating mode
);
  import hsw_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  hsw_pins_s pins_s1_ff, pins_s2_ff; // Pin stages
  hsw_supply_s sup_s1_ff, sup_s2_ff; // Supply stages
  hsw_pins_s nxt_pins_s1, nxt_pins_s2; // Next pin stages
  hsw_supply_s nxt_sup_s1, nxt_sup_s2; // Next supply stages

  // Two stages each; only the second is read by logic
  always_comb begin
    nxt_pins_s1 = pins; // [R1]
    nxt_pins_s2 = pins_s1_ff;
    nxt_sup_s1 = supply;
    nxt_sup_s2 = sup_s1_ff;
  end

  // Synchroniser registers
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pins_s1_ff <= '0;
      pins_s2_ff <= '0;
      sup_s1_ff <= '0;
      sup_s2_ff <= '0;
    end else begin
      pins_s1_ff <= nxt_pins_s1;
      pins_s2_ff <= nxt_pins_s2;
      sup_s1_ff <= nxt_sup_s1;
      sup_s2_ff <= nxt_sup_s2;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Supply state and restart wait
  logic uv_ff, nxt_uv; // Undervoltage flag with hysteresis
  logic wait_ff, nxt_wait; // Restart wait running
  logic [31:0] wait_cnt_ff, nxt_wait_cnt; // Restart wait counter
  hsw_mode_e mode_ff, nxt_mode; // Operating mode
  logic any_in; // Some channel requested

  assign any_in = |pins_s2_ff.chan_on;

  // Flag sets below trip, clears only above good level
  always_comb begin
    nxt_uv = uv_ff;
    if (sup_s2_ff.below_trip) begin
      nxt_uv = 1'b1; // [R13]
    end else if (sup_s2_ff.above_good) begin
      nxt_uv = 1'b0; // [R12]
    end
    nxt_wait = wait_ff;
    nxt_wait_cnt = wait_cnt_ff;
    if (nxt_uv) begin
      // Flag back before count ends: wait drops to zero at once
      nxt_wait = 1'b0; // [R16]
      nxt_wait_cnt = '0; // [R16]
    end else if (uv_ff) begin
      // Flag just released: wait starts from zero
      nxt_wait = 1'b1; // [R14]
      nxt_wait_cnt = '0;
    end else if (wait_ff) begin
      nxt_wait_cnt = wait_cnt_ff + 32'h0000_0001; // [R16]
      if (wait_cnt_ff == 32'(RESTART_CYCLES - 1)) begin
        nxt_wait = 1'b0; // [R14]
      end
    end
    // Sleep means nothing is pending; a wake-up switches at once
    if (nxt_mode == HSW_SLEEP) begin
      nxt_wait = 1'b0; // [R15]
      nxt_wait_cnt = '0;
    end
  end

  // Supply state registers
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      uv_ff <= UV_RST;
      wait_ff <= 1'b0;
      wait_cnt_ff <= '0;
    end else begin
      uv_ff <= nxt_uv;
      wait_ff <= nxt_wait;
      wait_cnt_ff <= nxt_wait_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Operating mode
  // Sleep needs every pin low and an idle retry counter
  always_comb begin
    case (mode_ff)
      HSW_SLEEP, HSW_STBY, HSW_ACTIVE: begin
        if (any_in) begin
          nxt_mode = HSW_ACTIVE; // [R10]
        end else if (pins_s2_ff.sense_en) begin
          nxt_mode = HSW_STBY; // [R9]
        end else if (pins_s2_ff.pick == '0 && !retry_busy) begin
          nxt_mode = HSW_SLEEP; // [R6] [R8]
        end else begin
          nxt_mode = HSW_STBY; // Held out of sleep [R8]
        end
      end
      default: begin
        nxt_mode = HSW_SLEEP;
      end
    endcase
  end

  // Mode register
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      mode_ff <= HSW_SLEEP;
    end else begin
      mode_ff <= nxt_mode;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Enable pulse length and latch clear
  logic den_prev_ff, nxt_den_prev; // Enable one cycle ago
  logic [DEN_LEN_W-1:0] den_len_ff, nxt_den_len; // High time of enable
  logic [NUM_CH-1:0] clr_ff, nxt_clr; // Clear pulse register

  // Short pulse clears only while the channel input is low
  always_comb begin
    nxt_den_prev = pins_s2_ff.sense_en;
    nxt_den_len = '0;
    nxt_clr = CH_OFF;
    if (pins_s2_ff.sense_en) begin
      nxt_den_len = (&den_len_ff) ? den_len_ff : den_len_ff + 16'h0001;
    end
    if (den_prev_ff && !pins_s2_ff.sense_en) begin
      if (!pins_s2_ff.chan_on[pins_s2_ff.pick] || den_len_ff >= DEN_MIN) begin
        nxt_clr[pins_s2_ff.pick] = 1'b1; // [R5]
      end
    end
  end

  // Latch clear registers
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      den_prev_ff <= 1'b0;
      den_len_ff <= '0;
      clr_ff <= CH_OFF;
    end else begin
      den_prev_ff <= nxt_den_prev;
      den_len_ff <= nxt_den_len;
      clr_ff <= nxt_clr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output stage
  logic [NUM_CH-1:0] drv_ff, nxt_drv; // Channel drive
  logic sen_oe_ff, nxt_sen_oe; // Sense driven
  logic [PICK_W-1:0] sel_ff, nxt_sel; // Sense channel
  logic diag_on_ff, nxt_diag_on; // On-state diagnosis
  logic prot_ff, nxt_prot; // Protection armed

  // Undervoltage overrides every mode; wait holds channels off
  always_comb begin
    nxt_drv = pins_s2_ff.chan_on; // [R2]
    if (nxt_uv || nxt_wait) begin
      nxt_drv = CH_OFF; // [R11] [R13] [R14]
    end
    nxt_sel = pins_s2_ff.pick; // [R4]
    nxt_sen_oe = pins_s2_ff.sense_en && !nxt_uv && nxt_mode != HSW_SLEEP; // [R3] [R11]
    nxt_diag_on = nxt_sen_oe && nxt_mode == HSW_ACTIVE; // [R9] [R10]
    nxt_prot = nxt_mode != HSW_SLEEP; // [R7]
  end

  // Output registers
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      drv_ff <= CH_OFF;
      sen_oe_ff <= 1'b0;
      sel_ff <= '0;
      diag_on_ff <= 1'b0;
      prot_ff <= 1'b0;
    end else begin
      drv_ff <= nxt_drv;
      sen_oe_ff <= nxt_sen_oe;
      sel_ff <= nxt_sel;
      diag_on_ff <= nxt_diag_on;
      prot_ff <= nxt_prot;
    end
  end

  assign chan_drive = drv_ff;
  assign sense_output_oe = sen_oe_ff;
  assign sense_sel = sel_ff;
  assign diag_on_state = diag_on_ff;
  assign protect_en = prot_ff;
  assign latch_clear = clr_ff;
  assign power_on = !uv_ff;
  assign mode = mode_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  sequence seq_uv_release;
    uv_ff ##1 !uv_ff;
  endsequence

  sequence seq_den_fall_low;
    den_prev_ff && !pins_s2_ff.sense_en && !pins_s2_ff.chan_on[pins_s2_ff.pick];
  endsequence

  AST_UV_OFF: assert property (uv_ff |-> chan_drive == CH_OFF && !sense_output_oe) // [R11]
    else $error("Channels or sense active during undervoltage");
  AST_SLEEP_OFF: assert property (mode == HSW_SLEEP |-> chan_drive == CH_OFF && !protect_en) // [R6]
    else $error("Sleep with channel or protection on");
  AST_SLEEP_PROT: assert property (nxt_mode == HSW_SLEEP |=> !protect_en) // [R7]
    else $error("Protection armed in sleep");
  AST_SLEEP_BUSY: assert property (retry_busy |=> mode != HSW_SLEEP) // [R8]
    else $error("Sleep entered with busy retry counter");
  AST_STBY: assert property (pins_s2_ff.sense_en && !any_in |=> mode == HSW_STBY) // [R9]
    else $error("Stand-by not entered");
  AST_ACTIVE: assert property (any_in |=> mode == HSW_ACTIVE && protect_en) // [R10]
    else $error("Active not entered");
  AST_SENSE_OFF: assert property (!pins_s2_ff.sense_en |=> !sense_output_oe) // [R3]
    else $error("Sense driven with enable low");
  AST_RESTART_HOLD: assert property (seq_uv_release ##0 mode_ff == HSW_ACTIVE
    |-> (chan_drive == CH_OFF) [*8]) // [R14]
    else $error("Channel restarted before wait");
  AST_WAIT_BOUND: assert property (wait_ff |-> wait_cnt_ff < 32'(RESTART_CYCLES)) // [R16]
    else $error("Restart wait overran");
  AST_UV_RESTARTS: assert property (wait_ff && sup_s2_ff.below_trip |=> wait_cnt_ff == '0) // [R16]
    else $error("Wait counter not restarted");
  AST_CLEAR: assert property (seq_den_fall_low |=> latch_clear[$past(pins_s2_ff.pick)]) // [R5]
    else $error("Latch clear missing");
  AST_PICK: assert property (##1 sense_sel == $past(pins_s2_ff.pick)) // [R4]
    else $error("Sense select not followed");
endmodule // hsw_ctrl

// [rtl/hsw_pkg.sv]
// Constants and carrier types for the four-channel load switch control
// Notes on behaviour
// R1: Seven logic inputs: four channel, enable, two select
// R2: Channel input high requests its channel on
// R3: Sense enable gates diagnosis; low floats sense output
// R4: Select lines pick the observed channel
// R5: Enable falling edge clears selected channel latch; code clears only if picked input low or pulse long
// R6: All inputs low means Sleep; all off
// R7: Protection inactive while in Sleep
// R8: Sleep only when restart counter is zero
// R9: Enable high, channels low means Stand-by
// R10: Any channel high means Active, full protection
// R11: Undervoltage holds channels and diagnosis off
// R12: Power-on raised only above good level
// R13: Trip level in Active switches channels off
// R14: Restart after recovery waits nominal 5 ms
// R15: Leaving Sleep skips the restart wait
// R16: Wait counter restarts if undervoltage returns
package hsw_pkg;
  localparam int NUM_CH = 4; // Output channels
  localparam int PICK_W = 2; // Select line width
  localparam int LOGIC_PINS = 7; // Channel, enable and select pins
  localparam int SYS_CLK_MHZ = 200; // Core clock rate
  localparam int RESTART_WAIT_US = 5000; // Nominal brownout_restart_wait
  localparam int RESTART_MIN_US = 2500; // Shortest allowed wait
  localparam int RESTART_MAX_US = 7500; // Longest allowed wait
  localparam int RESTART_CYC = RESTART_WAIT_US * SYS_CLK_MHZ; // Wait in cycles
  localparam int DEN_LEN_W = 16; // Enable pulse length counter width
  localparam logic [15:0] DEN_MIN_CYC = 16'h0010; // Long pulse clears regardless
  localparam logic UV_RST = 1'b1; // Supply counts as low at reset
  localparam logic [3:0] CH_OFF = 4'h0; // All channels off

  // Operating modes, Gray along sleep, stand-by, active
  typedef enum logic [1:0] {
    HSW_SLEEP = 2'b00,
    HSW_STBY = 2'b01,
    HSW_ACTIVE = 2'b11
  } hsw_mode_e;

  // The seven logic pins travel together
  typedef struct packed {
    logic [NUM_CH-1:0] chan_on; // channel_on_input
    logic sense_en; // sense_enable
    logic [PICK_W-1:0] pick; // sense_channel_pick
  } hsw_pins_s;

  // Supply comparator flags travel together
  typedef struct packed {
    logic below_trip; // Below supply_trip_level
    logic above_good; // Above supply_good_level
  } hsw_supply_s;
endpackage

// [tb/hsw_host.sv]
// Host microcontroller model driving logic pins and supply flags
`timescale 1ns/100ps
module hsw_host (
  input wire logic sys_clk, // Core clock
  output hsw_pkg::hsw_pins_s pins, // Seven logic pins
  output hsw_pkg::hsw_supply_s supply, // Supply comparator flags
  output logic retry_busy // Restart counter nonzero
);
  import hsw_pkg::*;
  // Start in undervoltage, every pin low
  initial begin
    pins = '0;
    supply = 2'h2;
    retry_busy = 1'h0;
  end
  // Drive all seven pins together, off the sampling edge
  task automatic put(input logic [3:0] ch, input logic en, input logic [1:0] pk,
                     input logic uv, input logic bz);
    @(negedge sys_clk);
    pins.chan_on = ch;
    pins.sense_en = en;
    pins.pick = pk;
    // Comparators are complementary, never both high
    supply = uv ? 2'h2 : 2'h1;
    retry_busy = bz;
  endtask
endmodule // hsw_host

// [tb/switch_mode_and_channel_control_tb.sv]
// Self-checking bench for the load switch control block
`timescale 1ns/100ps
module switch_mode_and_channel_control_tb;
  import hsw_pkg::*;
  localparam int WAIT_CYC = 50; // Shortened restart wait
  logic sys_clk = 1'h0; // Core clock
  logic resetn = 1'h0; // Reset, active low
  hsw_pins_s pins; // Host pins
  hsw_supply_s supply; // Supply flags
  logic retry_busy; // Restart counter busy
  logic [3:0] chan_drive; // Channel enables
  logic [3:0] latch_clear; // Clear pulses
  logic [3:0] clr_seen = 4'h0; // Sticky clear record
  logic sense_output_oe; // Sense driven
  logic diag_on_state; // On-state diagnosis
  logic protect_en; // Protection armed
  logic power_on; // Supply good
  logic [1:0] sense_sel; // Observed channel
  hsw_mode_e mode; // Operating mode
  int fail_count = 0; // Mismatches
  int checks = 0; // Comparisons
  always #2.5 sys_clk = ~sys_clk;
  hsw_host host (.sys_clk(sys_clk), .pins(pins), .supply(supply), .retry_busy(retry_busy));
  hsw_ctrl #(.RESTART_CYCLES(WAIT_CYC), .DEN_MIN(16'h0010)) uut (
    .sys_clk(sys_clk), .resetn(resetn), .pins(pins), .supply(supply),
    .retry_busy(retry_busy), .chan_drive(chan_drive), .sense_output_oe(sense_output_oe),
    .sense_sel(sense_sel), .diag_on_state(diag_on_state), .protect_en(protect_en),
    .latch_clear(latch_clear), .power_on(power_on), .mode(mode));
  // One-cycle pulses are caught here so a task can judge them later
  always @(posedge sys_clk) clr_seen <= clr_seen | latch_clear;
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // Apply pins and wait past the three-edge answer
  task automatic go(input logic [3:0] ch, input logic en, input logic [1:0] pk,
                    input logic uv, input logic bz);
    host.put(ch, en, pk, uv, bz);
    cyc(4);
  endtask
  task automatic close_out();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_power();
    cyc(1);
    chk(mode, HSW_SLEEP);
    chk(power_on, 1'h0);
    cyc(2);
    resetn = 1'h1;
    go(4'h0, 1'h0, 2'h0, 1'h1, 1'h0);
    chk(power_on, 1'h0);
    go(4'h0, 1'h0, 2'h0, 1'h0, 1'h0);
    chk(power_on, 1'h1);
    chk(mode, HSW_SLEEP);
    chk(protect_en, 1'h0);
  endtask
  // Waking from Sleep switches at once, no restart wait
  task automatic t_wake();
    go(4'h5, 1'h0, 2'h0, 1'h0, 1'h0);
    chk(mode, HSW_ACTIVE);
    chk(chan_drive, 4'h5);
    chk(protect_en, 1'h1);
    go(4'h1, 1'h0, 2'h0, 1'h0, 1'h0);
    chk(chan_drive, 4'h1);
  endtask
  task automatic t_stby();
    go(4'h0, 1'h1, 2'h2, 1'h0, 1'h0);
    chk(mode, HSW_STBY);
    chk({chan_drive, diag_on_state}, 5'h00);
    chk(sense_output_oe, 1'h1);
    chk(sense_sel, 2'h2);
  endtask
  // Short pulse clears only with the picked input low
  task automatic t_clear();
    go(4'h4, 1'h1, 2'h1, 1'h0, 1'h0);
    chk(diag_on_state, 1'h1);
    chk(sense_sel, 2'h1);
    clr_seen = 4'h0;
    go(4'h4, 1'h0, 2'h1, 1'h0, 1'h0);
    chk(clr_seen, 4'h2);
    chk(sense_output_oe, 1'h0);
    host.put(4'h4, 1'h1, 2'h2, 1'h0, 1'h0);
    clr_seen = 4'h0;
    go(4'h4, 1'h0, 2'h2, 1'h0, 1'h0);
    chk(clr_seen, 4'h0);
    host.put(4'h4, 1'h1, 2'h2, 1'h0, 1'h0);
    cyc(20);
    clr_seen = 4'h0;
    go(4'h4, 1'h0, 2'h2, 1'h0, 1'h0);
    chk(clr_seen, 4'h4);
  endtask
  // Brownout, recovery wait, and a wait restarted by a second trip
  task automatic t_brown();
    go(4'h3, 1'h1, 2'h0, 1'h0, 1'h0);
    chk(chan_drive, 4'h3);
    go(4'h3, 1'h1, 2'h0, 1'h1, 1'h0);
    chk(chan_drive, 4'h0);
    chk({power_on, sense_output_oe}, 2'h0);
    go(4'h3, 1'h1, 2'h0, 1'h0, 1'h0);
    chk(chan_drive, 4'h0);
    cyc(20);
    go(4'h3, 1'h1, 2'h0, 1'h1, 1'h0);
    host.put(4'h3, 1'h1, 2'h0, 1'h0, 1'h0);
    cyc(40);
    chk(chan_drive, 4'h0);
    cyc(20);
    chk(chan_drive, 4'h3);
  endtask
  task automatic t_busy();
    go(4'h0, 1'h0, 2'h0, 1'h0, 1'h1);
    chk(mode, HSW_STBY);
    go(4'h0, 1'h0, 2'h0, 1'h0, 1'h0);
    chk(mode, HSW_SLEEP);
    chk({chan_drive, protect_en}, 5'h00);
  endtask
  initial begin
    t_power();
    t_wake();
    t_stby();
    t_clear();
    t_brown();
    t_busy();
    close_out();
  end
  // Whole run is under two hundred cycles; this leaves ample room
  initial begin
    #5000;
    fail_count++;
    close_out();
  end
endmodule // switch_mode_and_channel_control_tb
